// ==== hdl/sufc_regs.sv ====
// Unknown-frame forwarding, self filter, rate-limit and DSCP registers
// Operation
// R1: Unknown multicast forwarding follows its port map only while bit 5 is set.
// R2: Unknown multicast map: 00000 filters, 00001 reserved, bit 0 ignored, 1111x all ports.
// R3: Unknown VLAN-ID forwarding follows its port map only while bit 5 is set.
// R4: Unknown VLAN-ID map uses the same decode: 0001x port 1, 0010x port 2, 0011x both.
// R5: Unknown IP multicast forwarding follows its own map only while bit 5 is set.
// R6: Unknown IP multicast map decodes zero as filter, 00001 reserved, 1111x all.
// R7: Bit 6 enables dropping frames whose address matches the switch address.
// R8: The self-address compare is done at egress against the six address bytes.
// R9: Rate period 00 is 16 ms, 01 is 64 ms, 1x is 256 ms, reset value 01.
// R10: Bit 3 picks per-port (0, reset) or per-queue (1) egress rate limiting.
// R11: Bit 2 makes tag insertion follow per-source settings, else the global bit.
// R12: Identification register shows a fixed read-only revision in bits 7-4.
// R13: Every one of the 64 six-bit codes owns its own two-bit priority field.
// R14: Code 0x03 takes its priority from bits 7-6 of the first table register.
// R15: Bits 1-0, 3-2, 5-4 of each table register serve codes 4n, 4n+1, 4n+2.
// R16: Reserved bits ignore writes and read defaults; fields reset to defaults.
`timescale 1ns/1ps
`default_nettype none
module sufc_regs #(
    parameter logic [3:0] REVISION = 4'h9 // Arbitrary neutral value
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic [5:0] i_tos_code,
    output logic [1:0] o_tos_priority,
    input wire logic [47:0] i_self_mac,
    input wire logic [47:0] i_frame_da,
    output logic o_self_drop,
    output sufc_pkg::sufc_fwd_s o_unk_mcast,
    output sufc_pkg::sufc_fwd_s o_unk_vid,
    output sufc_pkg::sufc_fwd_s o_unk_ipmc,
    output logic [8:0] o_rl_period_ms,
    output logic [23:0] o_rl_period_cyc,
    output logic o_queue_egress_rl,
    output logic o_src_port_tag_sel
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] unk_mcast_q;
    logic [7:0] unk_vid_q;
    logic [7:0] self_ipmc_q;
    logic [7:0] rate_tag_q;
    logic [7:0] dscp_q [sufc_pkg::DSCP_REGS];
    logic [7:0] rdata_q;

    wire logic wr_mcast = i_wr && (i_addr == sufc_pkg::ADDR_UNK_MCAST);
    wire logic wr_vid = i_wr && (i_addr == sufc_pkg::ADDR_UNK_VID);
    wire logic wr_self = i_wr && (i_addr == sufc_pkg::ADDR_SELF_IPMC);
    wire logic wr_rate = i_wr && (i_addr == sufc_pkg::ADDR_RATE_TAG);
    wire logic [3:0] dscp_idx = i_addr[3:0];
    wire logic dscp_hit = (i_addr[7:4] == sufc_pkg::ADDR_DSCP_BASE[7:4]);

    // ------------------------------------------------------------
    // Control registers, reserved bits masked
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unk_mcast_q <= sufc_pkg::RST_UNK_MCAST; // R16
            unk_vid_q <= sufc_pkg::RST_UNK_VID;
            self_ipmc_q <= sufc_pkg::RST_SELF_IPMC;
            rate_tag_q <= sufc_pkg::RST_RATE_TAG; // R9
        end else begin
            if (wr_mcast) begin
                unk_mcast_q <= i_wdata & sufc_pkg::WMASK_FWD; // R16
            end
            if (wr_vid) begin
                unk_vid_q <= i_wdata & sufc_pkg::WMASK_FWD; // R16
            end
            if (wr_self) begin
                self_ipmc_q <= i_wdata & sufc_pkg::WMASK_SELF_IPMC; // R16
            end
            if (wr_rate) begin
                rate_tag_q <= (i_wdata & sufc_pkg::WMASK_RATE_TAG); // R16
            end
        end
    end

    // ------------------------------------------------------------
    // Priority table, one register per four codes
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < sufc_pkg::DSCP_REGS; g++) begin : g_dscp
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    dscp_q[g] <= sufc_pkg::RST_DSCP;
                end else if (i_wr && dscp_hit && dscp_idx == 4'(g)) begin
                    dscp_q[g] <= i_wdata & sufc_pkg::WMASK_DSCP;
                end
            end
        end
    endgenerate

    // Full decode: upper code bits pick register, low two pick field
    wire logic [7:0] dscp_sel = dscp_q[i_tos_code[5:2]]; // R13 R15
    wire logic [2:0] fld_lsb = {i_tos_code[1:0], 1'b0};
    assign o_tos_priority = dscp_sel[fld_lsb +: 2]; // R13 R14 R15

    // ------------------------------------------------------------
    // Read path, registered
    // ------------------------------------------------------------
    wire logic [7:0] id_val = {REVISION, 4'h0}; // R12
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (i_addr)
            sufc_pkg::ADDR_UNK_MCAST: rd_mux = unk_mcast_q;
            sufc_pkg::ADDR_UNK_VID: rd_mux = unk_vid_q;
            sufc_pkg::ADDR_SELF_IPMC: rd_mux = self_ipmc_q;
            sufc_pkg::ADDR_RATE_TAG: rd_mux = rate_tag_q;
            sufc_pkg::ADDR_CHIP_ID: rd_mux = id_val; // R12
            default: begin
                if (dscp_hit) begin
                    rd_mux = dscp_q[dscp_idx];
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // Port map decode shared by the three frame classes
    // ------------------------------------------------------------
    function automatic sufc_pkg::sufc_fwd_s decode_map(input logic [7:0] r);
        sufc_pkg::sufc_fwd_s f;
        f = '0;
        f.fwd_en = r[sufc_pkg::BIT_FWD_EN];
        f.reserved = (r[4:0] == sufc_pkg::MAP_RESERVED);
        // Bit 0 ignored, so only bits 4:1 steer the ports
        // Only all zeros, or a clear bit 5, filters; the reserved code 00001 steers nowhere
        f.filter = (r[4:0] == {sufc_pkg::MAP_FILTER, 1'b0}) || !f.fwd_en;
        case (r[4:1])
            sufc_pkg::MAP_PORT1: f.port_mask = 4'b0001;
            sufc_pkg::MAP_PORT2: f.port_mask = 4'b0010;
            sufc_pkg::MAP_BOTH: f.port_mask = 4'b0011;
            sufc_pkg::MAP_ALL: f.port_mask = 4'b1111;
            default: f.port_mask = 4'b0000;
        endcase
        // Disabled feature never steers frames
        if (!f.fwd_en) begin
            f.port_mask = 4'b0000;
        end
        return f;
    endfunction : decode_map

    assign o_unk_mcast = decode_map(unk_mcast_q); // R1 R2
    assign o_unk_vid = decode_map(unk_vid_q); // R3 R4
    assign o_unk_ipmc = decode_map({2'b00, self_ipmc_q[5:0]}); // R5 R6

    // ------------------------------------------------------------
    // Self-address filter, used by egress
    // ------------------------------------------------------------
    wire logic self_en = self_ipmc_q[sufc_pkg::BIT_SELF_FILT];
    assign o_self_drop = self_en && (i_frame_da == i_self_mac); // R7 R8

    // ------------------------------------------------------------
    // Rate limiting and tag selection
    // ------------------------------------------------------------
    wire logic [1:0] rl_sel = rate_tag_q[sufc_pkg::POS_RL_PERIOD +: 2];
    logic [8:0] period_ms;
    always_comb begin
        period_ms = 9'(sufc_pkg::PERIOD_256_MS);
        case (rl_sel)
            2'b00: period_ms = 9'(sufc_pkg::PERIOD_16_MS); // R9
            2'b01: period_ms = 9'(sufc_pkg::PERIOD_64_MS); // R9
            default: period_ms = 9'(sufc_pkg::PERIOD_256_MS); // R9
        endcase
    end
    assign o_rl_period_ms = period_ms;
    assign o_rl_period_cyc = 24'(period_ms * sufc_pkg::CYC_PER_MS);
    assign o_queue_egress_rl = rate_tag_q[sufc_pkg::BIT_QUEUE_EGR]; // R10
    assign o_src_port_tag_sel = rate_tag_q[sufc_pkg::BIT_SRC_TAG]; // R11

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Table must give every code its own field
    if (sufc_pkg::DSCP_REGS * 4 != sufc_pkg::DSCP_CODES) begin : g_bad_table
        $error("Priority table does not cover every code");
    end
    if (REVISION == 4'h0) begin : g_bad_rev
        $error("Revision code must be nonzero");
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    mcast_gate_a: assert property ( // R1
        !unk_mcast_q[5] |-> o_unk_mcast.port_mask == 4'h0)
        else $error("Disabled multicast forward steers ports");

    mcast_all_a: assert property ( // R2
        unk_mcast_q[5] && unk_mcast_q[4:1] == 4'hf
        |-> o_unk_mcast.port_mask == 4'hf)
        else $error("Multicast broadcast code not decoded");

    mcast_rsvd_a: assert property ( // R2
        unk_mcast_q[5] && unk_mcast_q[4:0] == 5'h01
        |-> o_unk_mcast.reserved && !o_unk_mcast.filter)
        else $error("Multicast reserved code misread");

    mcast_filt_a: assert property ( // R2
        unk_mcast_q[5:0] == 6'h20 |-> o_unk_mcast.filter)
        else $error("Multicast zero code not filtering");

    vid_both_a: assert property ( // R4
        unk_vid_q[5] && unk_vid_q[4:1] == 4'h3
        |-> o_unk_vid.port_mask == 4'h3)
        else $error("VLAN_IDENTIFIER both-port code wrong");

    vid_port1_a: assert property ( // R4
        unk_vid_q[5] && unk_vid_q[4:1] == 4'h1
        |-> o_unk_vid.port_mask == 4'h1)
        else $error("VLAN_IDENTIFIER port-one code wrong");

    vid_gate_a: assert property ( // R3
        !unk_vid_q[5] |-> o_unk_vid.filter)
        else $error("Disabled VLAN_IDENTIFIER forward not filtering");

    ipmc_write_a: assert property ( // R5 R6
        wr_self ##1 1 |-> o_unk_ipmc.fwd_en == $past(i_wdata[5]))
        else $error("IP multicast enable not taken");

    ipmc_gate_a: assert property ( // R5
        !self_ipmc_q[5] |-> o_unk_ipmc.port_mask == 4'h0)
        else $error("Disabled IP multicast steers ports");

    ipmc_port2_a: assert property ( // R6
        self_ipmc_q[5] && self_ipmc_q[4:1] == 4'h2
        |-> o_unk_ipmc.port_mask == 4'h2)
        else $error("IP multicast port-two code wrong");

    self_drop_a: assert property ( // R7 R8
        o_self_drop |-> self_ipmc_q[6] && i_frame_da == i_self_mac)
        else $error("Self drop without cause");

    self_hit_a: assert property ( // R7 R8
        self_ipmc_q[6] && i_frame_da == i_self_mac |-> o_self_drop)
        else $error("Self address not dropped");

    period_a: assert property ( // R9
        rl_sel == 2'b00 |-> o_rl_period_ms == 9'd16)
        else $error("Period code 00 wrong");

    period_mid_a: assert property ( // R9
        rl_sel == 2'b01 |-> o_rl_period_ms == 9'd64)
        else $error("Period code 01 wrong");

    period_long_a: assert property ( // R9
        rl_sel[1] |-> o_rl_period_ms == 9'd256)
        else $error("Period code 1x wrong");

    rsvd_rate_a: assert property ( // R16
        rate_tag_q[7:6] == 2'b00 && rate_tag_q[1:0] == 2'b00)
        else $error("Reserved rate bits set");

    rsvd_fwd_a: assert property ( // R16
        unk_mcast_q[7:6] == 2'b00 && unk_vid_q[7:6] == 2'b00
        && !self_ipmc_q[7])
        else $error("Reserved forward bits set");

    queue_sel_a: assert property ( // R10
        wr_rate |=> o_queue_egress_rl == $past(i_wdata[3]))
        else $error("Queue select not updated");

    tag_sel_a: assert property ( // R11
        wr_rate |=> o_src_port_tag_sel == $past(i_wdata[2]))
        else $error("Tag select not updated");

    rev_a: assert property ( // R12
        i_addr == sufc_pkg::ADDR_CHIP_ID |=> o_rdata == {REVISION, 4'h0})
        else $error("Revision readback wrong");

    code3_a: assert property ( // R14
        i_tos_code == 6'h03 |-> o_tos_priority == dscp_q[0][7:6])
        else $error("Code 3 priority wrong");

    code_fld_a: assert property ( // R13 R15
        i_tos_code[1:0] == 2'b00
        |-> o_tos_priority == dscp_q[i_tos_code[5:2]][1:0])
        else $error("Field 0 priority wrong");

    code_fld1_a: assert property ( // R13 R15
        i_tos_code[1:0] == 2'b01
        |-> o_tos_priority == dscp_q[i_tos_code[5:2]][3:2])
        else $error("Field 1 priority wrong");

    code_fld2_a: assert property ( // R13 R15
        i_tos_code[1:0] == 2'b10
        |-> o_tos_priority == dscp_q[i_tos_code[5:2]][5:4])
        else $error("Field 2 priority wrong");

    c_mcast_c: cover property (wr_mcast ##1 o_unk_mcast.port_mask == 4'hf);
    c_drop_c: cover property (o_self_drop);
    c_queue_c: cover property (wr_rate ##1 o_queue_egress_rl);
    c_dscp_c: cover property (i_wr && dscp_hit ##1 o_tos_priority != 2'b00);
    c_rsvd_c: cover property (o_unk_vid.reserved);
endmodule : sufc_regs
`default_nettype wire

// ==== include/sufc_pkg.sv ====
// Package: register map, field layout and timing constants for sufc block
package sufc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_UNK_MCAST = 8'h84;
    localparam logic [7:0] ADDR_UNK_VID = 8'h85;
    localparam logic [7:0] ADDR_SELF_IPMC = 8'h86;
    localparam logic [7:0] ADDR_RATE_TAG = 8'h87;
    localparam logic [7:0] ADDR_CHIP_ID = 8'h89;
    localparam logic [7:0] ADDR_DSCP_BASE = 8'h90;
    localparam int DSCP_REGS = 16;
    localparam int DSCP_CODES = 64;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_FWD_EN = 5;
    localparam int BIT_SELF_FILT = 6;
    localparam int BIT_QUEUE_EGR = 3;
    localparam int BIT_SRC_TAG = 2;
    localparam int POS_RL_PERIOD = 4;
    localparam int POS_REV = 4;
    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_UNK_MCAST = 8'h00;
    localparam logic [7:0] RST_UNK_VID = 8'h00;
    localparam logic [7:0] RST_SELF_IPMC = 8'h00;
    localparam logic [7:0] RST_RATE_TAG = 8'h10;
    localparam logic [7:0] RST_DSCP = 8'h00;
    localparam logic [7:0] WMASK_FWD = 8'h3f;
    localparam logic [7:0] WMASK_SELF_IPMC = 8'h7f;
    localparam logic [7:0] WMASK_RATE_TAG = 8'h3c;
    localparam logic [7:0] WMASK_DSCP = 8'hff;
    // ------------------------------------------------------------
    // Port map codes
    // ------------------------------------------------------------
    localparam logic [3:0] MAP_FILTER = 4'h0;
    localparam logic [3:0] MAP_PORT1 = 4'h1;
    localparam logic [3:0] MAP_PORT2 = 4'h2;
    localparam logic [3:0] MAP_BOTH = 4'h3;
    localparam logic [3:0] MAP_ALL = 4'hf;
    localparam logic [4:0] MAP_RESERVED = 5'h01;
    // ------------------------------------------------------------
    // Rate-limit periods
    // ------------------------------------------------------------
    localparam int PERIOD_16_MS = 16;
    localparam int PERIOD_64_MS = 64;
    localparam int PERIOD_256_MS = 256;
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // Decoded forward decision of one frame class
    typedef struct packed {
        logic fwd_en;
        logic filter;
        logic reserved;
        logic [3:0] port_mask;
    } sufc_fwd_s;
endpackage : sufc_pkg

// ==== test/sufc_regs_bench.sv ====
// Self-checking bench for the unknown-forward control registers
`timescale 1ns/1ps
`default_nettype none
module sufc_regs_bench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    localparam logic [3:0] REV = 4'ha; // Arbitrary revision value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [5:0] tos = 6'h00;
    logic [47:0] mac = 48'h0a1b_2c3d_4e5f;
    logic [47:0] da = 48'h0000_0000_0000;
    logic [7:0] rdata;
    logic [1:0] prio;
    logic drop;
    sufc_pkg::sufc_fwd_s fwd [3];
    logic [8:0] per_ms;
    logic [23:0] per_cyc;
    logic q_rl;
    logic tag_sel;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int ms;
    logic [7:0] tbl [16];
    logic [5:0] v;
    logic [3:0] m;
    // Address list, reset values and read-back after writing all ones
    logic [7:0] ra [8] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
                           8'h90, 8'h9f};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, {REV, 4'h0},
                           8'h00, 8'h00};
    logic [7:0] wm [8] = '{8'h3f, 8'h3f, 8'h7f, 8'h3c, 8'h00, {REV, 4'h0},
                           8'hff, 8'hff};
    // Odd codes and the unlisted 0100x probe the ignored bit and default
    logic [4:0] codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07,
                              5'h08, 5'h1e, 5'h1f};

    sufc_regs #(.REVISION(REV)) DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
        .i_wdata(wdata), .o_rdata(rdata), .i_tos_code(tos),
        .o_tos_priority(prio), .i_self_mac(mac), .i_frame_da(da),
        .o_self_drop(drop), .o_unk_mcast(fwd[0]), .o_unk_vid(fwd[1]),
        .o_unk_ipmc(fwd[2]), .o_rl_period_ms(per_ms),
        .o_rl_period_cyc(per_cyc), .o_queue_egress_rl(q_rl),
        .o_src_port_tag_sel(tag_sel));

    always #25 clk = ~clk;

    // ------------------------------------------------------------
    // Access tasks and verdict
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    // Data is registered, so it is looked at one cycle after the address
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check($sformatf("rdata at %h", a), {24'h0, rdata}, {24'h0, exp});
    endtask : rd_chk

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check("period at reset", 32'(per_ms), 32'd64);
        foreach (ra[i]) rd_chk(ra[i], rv[i]);
        foreach (ra[i]) wr_reg(ra[i], 8'hff);
        foreach (ra[i]) rd_chk(ra[i], wm[i]);
        for (int p = 0; p < 4; p++) begin
            wr_reg(sufc_pkg::ADDR_RATE_TAG, {2'b00, 2'(p), 4'h0});
            ms = (p == 0) ? 16 : ((p == 1) ? 64 : 256);
            check("period ms", 32'(per_ms), 32'(ms));
            check("period cyc", 32'(per_cyc), 32'(ms * 20000));
            check("flags", {30'h0, q_rl, tag_sel}, 32'h0);
        end
        wr_reg(sufc_pkg::ADDR_RATE_TAG, 8'h08);
        check("flags", {30'h0, q_rl, tag_sel}, 32'h2);
        wr_reg(sufc_pkg::ADDR_RATE_TAG, 8'h04);
        check("flags", {30'h0, q_rl, tag_sel}, 32'h1);
        for (int k = 0; k < 3; k++) begin
            foreach (codes[i]) begin
                for (int e = 0; e < 2; e++) begin
                    v = {1'(e), codes[i]};
                    wr_reg(8'(8'h84 + k), {2'b00, v});
                    case (v[4:1])
                        4'h1, 4'h2, 4'h3, 4'hf: m = v[4:1];
                        default: m = 4'h0;
                    endcase
                    if (e == 0) begin
                        check("map off", {fwd[k].fwd_en, fwd[k].filter,
                            fwd[k].port_mask}, 32'h10);
                    end else begin
                        check("map on", {fwd[k].fwd_en, fwd[k].filter,
                            fwd[k].reserved, fwd[k].port_mask},
                            {25'h0, 1'b1, v[4:0] == 5'h00,
                            v[4:0] == 5'h01, m});
                    end
                end
            end
        end
        // Self filter: disabled, enabled, then a near-miss address
        da = mac;
        wr_reg(sufc_pkg::ADDR_SELF_IPMC, 8'h00);
        check("self drop off", {31'h0, drop}, 32'h0);
        wr_reg(sufc_pkg::ADDR_SELF_IPMC, 8'h40);
        check("self drop on", {31'h0, drop}, 32'h1);
        @(negedge clk);
        da = mac ^ 48'h0100_0000_0000;
        @(posedge clk);
        check("self drop miss", {31'h0, drop}, 32'h0);
        for (int n = 0; n < 16; n++) begin
            tbl[n] = 8'(n * 27) ^ 8'h5a;
            wr_reg(8'(8'h90 + n), tbl[n]);
        end
        for (int c = 0; c < 64; c++) begin
            @(negedge clk);
            tos = 6'(c);
            @(posedge clk);
            check($sformatf("priority of %h", c), 32'(prio),
                32'(tbl[c / 4][2 * (c % 4) +: 2]));
        end
        // Reset again in mid-run
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        check("period after reset", 32'(per_ms), 32'd64);
        rd_chk(sufc_pkg::ADDR_RATE_TAG, 8'h10);
        rd_chk(sufc_pkg::ADDR_DSCP_BASE, 8'h00);
        conclude();
    end
endmodule : sufc_regs_bench
`default_nettype wire
